// ==== fetch_core_defines.vh ====
// Purpose: constants for the fetch, stack and interrupt control core
// Assumes: word-addressed program memory, byte-addressed data sram
// Notes: none
`ifndef FETCH_CORE_DEFINES_VH
`define FETCH_CORE_DEFINES_VH
`define PC_RESET 16'h0000
`define STACK_POINTER_RESET 16'h0000
`define STATUS_RESET 8'h00
`define WORD_RESET 16'h0000
`define BYTE_RESET 8'h00
`define STATUS_IE_BIT 7
`define IO_STACK_LO 6'h3D
`define IO_STACK_HI 6'h3E
`define IO_STATUS 6'h3F
`define VEC_BASE 16'h0000
`define VEC_STRIDE 16'h0002
`endif

// ==== fetch_core.v ====
// Purpose: fetch pipeline, return stack and interrupt entry control
// Assumes: program word valid while its address stands, data sram write takes one cycle
// Notes: instruction decode lives outside; it raises call_req with a target
`timescale 1ns/1ps
`include "fetch_core_defines.vh"
module fetch_core #(
	parameter N_IRQ = 8
) (
	input wire clk_sys,
	input wire rst_n,
	output reg [15:0] prog_addr_reg,
	input wire [15:0] prog_data,
	output reg [15:0] instr_reg,
	output reg instr_valid_reg,
	input wire call_req,
	input wire [15:0] call_target,
	input wire jump_req,
	input wire [15:0] jump_target,
	input wire [N_IRQ-1:0] irq_pending,
	output reg [N_IRQ-1:0] irq_ack_reg,
	input wire io_we,
	input wire [5:0] io_addr,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata_reg,
	output reg [15:0] data_addr_reg,
	output reg [7:0] data_wdata_reg,
	output reg data_we_reg
);
	localparam [1:0] ST_RUN = 2'h0;
	localparam [1:0] ST_PUSH_LO = 2'h1;
	localparam [1:0] ST_PUSH_HI = 2'h2;
	localparam [1:0] ST_FLUSH = 2'h3;
	localparam [1:0] IO_NONE = 2'h0;
	localparam [1:0] IO_LO = 2'h1;
	localparam [1:0] IO_HI = 2'h2;
	localparam [1:0] IO_STAT = 2'h3;

	reg [15:0] pc_reg;
	reg [15:0] pc_next;
	reg [15:0] prog_addr_next;
	reg [15:0] instr_next;
	reg instr_valid_next;
	reg [15:0] stack_pointer_reg;
	reg [15:0] stack_pointer_next;
	reg [7:0] status_reg;
	reg [7:0] status_next;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [15:0] ret_reg;
	reg [15:0] ret_next;
	reg [15:0] tgt_reg;
	reg [15:0] tgt_next;
	reg [N_IRQ-1:0] sel_reg;
	reg [N_IRQ-1:0] sel_next;
	reg irq_entry_reg;
	reg irq_entry_next;
	reg [N_IRQ-1:0] irq_ack_next;
	reg [7:0] io_rdata_next;
	reg [15:0] data_addr_next;
	reg [7:0] data_wdata_next;
	reg data_we_next;
	wire [N_IRQ-1:0] irq_grant;
	wire [N_IRQ:0] irq_seen;
	wire [15:0] irq_vector;
	wire irq_take;
	wire [1:0] io_wsel;
	genvar g;

	// maps an i/o offset onto one of the core's own byte registers
	function [1:0] io_decode;
		input [5:0] addr;
		begin
			case (addr)
				`IO_STACK_LO: io_decode = IO_LO;
				`IO_STACK_HI: io_decode = IO_HI;
				`IO_STATUS: io_decode = IO_STAT;
				default: io_decode = IO_NONE;
			endcase
		end
	endfunction

	// source k maps to base + k*stride; one-hot grant expected
	function [15:0] vector_of;
		input [N_IRQ-1:0] grant;
		integer k;
		reg [15:0] idx;
		begin
			vector_of = `VEC_BASE;
			idx = 16'h0000;
			for (k = 0; k < N_IRQ; k = k + 1) begin
				if (grant[k])
					vector_of = `VEC_BASE + `VEC_STRIDE * idx;
				idx = idx + 16'h0001;
			end
		end
	endfunction

	// a source wins only while no lower-numbered source is pending
	assign irq_seen[0] = 1'b0;
	generate
		for (g = 0; g < N_IRQ; g = g + 1) begin : g_prio
			assign irq_grant[g] = irq_pending[g] & ~irq_seen[g];
			assign irq_seen[g + 1] = irq_seen[g] | irq_pending[g];
		end
	endgenerate

	assign irq_vector = vector_of(irq_grant);
	// masked sources simply wait; entry only between instructions
	assign irq_take = (state_reg == ST_RUN) && status_reg[`STATUS_IE_BIT] && (|irq_pending);
	assign io_wsel = io_we ? io_decode(io_addr) : IO_NONE;

	// read data lags the address by one cycle
	always @* begin
		case (io_decode(io_addr))
			IO_LO: io_rdata_next = stack_pointer_reg[7:0];
			IO_HI: io_rdata_next = stack_pointer_reg[15:8];
			IO_STAT: io_rdata_next = status_reg;
			default: io_rdata_next = 8'h00;
		endcase
	end

	always @* begin
		pc_next = pc_reg;
		prog_addr_next = prog_addr_reg;
		instr_next = instr_reg;
		instr_valid_next = instr_valid_reg;
		stack_pointer_next = stack_pointer_reg;
		status_next = status_reg;
		state_next = state_reg;
		ret_next = ret_reg;
		tgt_next = tgt_reg;
		sel_next = sel_reg;
		irq_entry_next = irq_entry_reg;
		irq_ack_next = {N_IRQ{1'b0}};
		data_addr_next = data_addr_reg;
		data_wdata_next = data_wdata_reg;
		data_we_next = 1'b0;
		// software writes first; the sequencer below overrides them
		if (io_wsel == IO_LO)
			stack_pointer_next[7:0] = io_wdata;
		if (io_wsel == IO_HI)
			stack_pointer_next[15:8] = io_wdata;
		if (io_wsel == IO_STAT)
			status_next = io_wdata;
		case (state_reg)
			ST_RUN: begin
				// program bus runs alone; data bus stays free for the datapath
				if (irq_take || call_req) begin
					instr_valid_next = 1'b0;
					ret_next = pc_reg;
					tgt_next = irq_take ? irq_vector : call_target;
					sel_next = irq_take ? irq_grant : {N_IRQ{1'b0}};
					irq_entry_next = irq_take;
					state_next = ST_PUSH_LO;
				end else if (jump_req) begin
					instr_valid_next = 1'b0;
					pc_next = jump_target;
					prog_addr_next = jump_target;
					state_next = ST_FLUSH;
				end else begin
					// word at prog_addr is the instruction from the next edge on
					instr_next = prog_data;
					instr_valid_next = 1'b1;
					pc_next = prog_addr_reg;
					prog_addr_next = prog_addr_reg + 16'h0001;
				end
			end
			ST_PUSH_LO: begin
				// no bound check on the stack; software owns its placement
				data_addr_next = stack_pointer_reg;
				data_wdata_next = ret_reg[7:0];
				data_we_next = 1'b1;
				stack_pointer_next = stack_pointer_reg - 16'h0001;
				state_next = ST_PUSH_HI;
			end
			ST_PUSH_HI: begin
				data_addr_next = stack_pointer_reg;
				data_wdata_next = ret_reg[15:8];
				data_we_next = 1'b1;
				stack_pointer_next = stack_pointer_reg - 16'h0001;
				pc_next = tgt_reg;
				prog_addr_next = tgt_reg;
				if (irq_entry_reg) begin
					// hardware clear beats a software write in the same cycle
					status_next[`STATUS_IE_BIT] = 1'b0;
					irq_ack_next = sel_reg;
				end
				state_next = ST_FLUSH;
			end
			ST_FLUSH: begin
				// one bubble while the new target word settles
				state_next = ST_RUN;
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= `PC_RESET;
			prog_addr_reg <= `PC_RESET;
			instr_reg <= `WORD_RESET;
			instr_valid_reg <= 1'b0;
			stack_pointer_reg <= `STACK_POINTER_RESET;
			status_reg <= `STATUS_RESET;
			state_reg <= ST_RUN;
			ret_reg <= `WORD_RESET;
			tgt_reg <= `WORD_RESET;
			sel_reg <= {N_IRQ{1'b0}};
			irq_entry_reg <= 1'b0;
			irq_ack_reg <= {N_IRQ{1'b0}};
			io_rdata_reg <= `BYTE_RESET;
			data_addr_reg <= `WORD_RESET;
			data_wdata_reg <= `BYTE_RESET;
			data_we_reg <= 1'b0;
		end else begin
			pc_reg <= pc_next;
			prog_addr_reg <= prog_addr_next;
			instr_reg <= instr_next;
			instr_valid_reg <= instr_valid_next;
			stack_pointer_reg <= stack_pointer_next;
			status_reg <= status_next;
			state_reg <= state_next;
			ret_reg <= ret_next;
			tgt_reg <= tgt_next;
			sel_reg <= sel_next;
			irq_entry_reg <= irq_entry_next;
			irq_ack_reg <= irq_ack_next;
			io_rdata_reg <= io_rdata_next;
			data_addr_reg <= data_addr_next;
			data_wdata_reg <= data_wdata_next;
			data_we_reg <= data_we_next;
		end
	end
endmodule

// ==== fetch_core_monitor.sv ====
// Purpose: port checker
// Assumes: one clock, asynchronous active-low reset
// Notes: bound below
`timescale 1ns/1ps
module fetch_core_monitor #(
	parameter N_IRQ = 8
) (
	input wire clk_sys,
	input wire rst_n,
	input wire instr_valid_reg,
	input wire call_req,
	input wire jump_req,
	input wire data_we_reg,
	input wire io_we,
	input wire [15:0] prog_addr_reg,
	input wire [15:0] prog_data,
	input wire [15:0] instr_reg,
	input wire [15:0] data_addr_reg,
	input wire [N_IRQ-1:0] irq_pending,
	input wire [N_IRQ-1:0] irq_ack_reg,
	input wire [5:0] io_addr,
	input wire [7:0] io_wdata,
	input wire [7:0] io_rdata_reg
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire run = instr_valid_reg & !call_req & !jump_req & ~|irq_pending;
	wire ak = |irq_ack_reg;
	property p_pre; run |=> prog_addr_reg == $past(prog_addr_reg) + 16'h0001; endproperty
	a_pre: assert property (p_pre) else $error("pre");
	property p_one; run |=> instr_valid_reg && instr_reg == $past(prog_data); endproperty
	a_one: assert property (p_one) else $error("one");
	property p_psh; instr_valid_reg & call_req |=> ##1 data_we_reg ##1 data_we_reg &&
		data_addr_reg == $past(data_addr_reg) - 16'h0001; endproperty
	a_psh: assert property (p_psh) else $error("psh");
	property p_hot; $onehot0(irq_ack_reg); endproperty
	a_hot: assert property (p_hot) else $error("hot");
	property p_pri; ak |-> irq_ack_reg == ($past(irq_pending, 3) & -$past(irq_pending, 3)); endproperty
	a_pri: assert property (p_pri) else $error("pri");
	property p_ack; ak |-> data_we_reg && $past(data_we_reg); endproperty
	a_ack: assert property (p_ack) else $error("ack");
	property p_fl; ak |=> !instr_valid_reg ##1 instr_valid_reg; endproperty
	a_fl: assert property (p_fl) else $error("fl");
	property p_stk_lo; io_we && io_addr == 6'h3D ##1 !io_we && io_addr == 6'h3D |=> io_rdata_reg == $past(io_wdata, 2);
	endproperty
	a_stk_lo: assert property (p_stk_lo) else $error("stack low");
endmodule
bind fetch_core fetch_core_monitor #(
	.N_IRQ(N_IRQ)
) mon (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.instr_valid_reg(instr_valid_reg),
	.call_req(call_req),
	.jump_req(jump_req),
	.data_we_reg(data_we_reg),
	.io_we(io_we),
	.prog_addr_reg(prog_addr_reg),
	.prog_data(prog_data),
	.instr_reg(instr_reg),
	.data_addr_reg(data_addr_reg),
	.irq_pending(irq_pending),
	.irq_ack_reg(irq_ack_reg),
	.io_addr(io_addr),
	.io_wdata(io_wdata),
	.io_rdata_reg(io_rdata_reg)
);

// ==== mem_model.sv ====
// Purpose: memories beside the core
// Assumes: word at a is {a[7:0],~a[7:0]}
// Notes: comb read fits the fetch walk
`timescale 1ns/1ps
module mem_model (
	input wire clk_sys,
	input wire data_we_reg,
	input wire [15:0] prog_addr_reg,
	input wire [15:0] data_addr_reg,
	input wire [7:0] data_wdata_reg,
	output wire [15:0] prog_data
);
	reg [7:0] sram [0:511];
	assign prog_data = {prog_addr_reg[7:0], ~prog_addr_reg[7:0]};
	always @(posedge clk_sys) if (data_we_reg) sram[data_addr_reg[8:0]] <= data_wdata_reg;
endmodule

// ==== fetch_core_tb_top.sv ====
// Purpose: bench
// Assumes: mem_model far side
// Notes: jump, call and interrupt entry each run once
`timescale 1ns/1ps
`define CHK(n,e,a) begin samples_checked++; if ((a)!==(e)) begin error_cnt++; $display("[ERR] %s %h %h",n,e,a); end end
module fetch_core_tb_top;
	reg clk_sys=0, rst_n=0, call_req=0, jump_req=0, io_we=0;
	reg [15:0] call_target=0, jump_target=0, r;
	reg [7:0] irq_pending=0, io_wdata=0;
	reg [5:0] io_addr=0;
	wire [15:0] prog_addr_reg, prog_data, instr_reg, data_addr_reg;
	wire [7:0] irq_ack_reg, io_rdata_reg, data_wdata_reg;
	wire instr_valid_reg, data_we_reg;
	integer error_cnt=0, samples_checked=0, cyc=0, i;
	fetch_core dut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.prog_addr_reg(prog_addr_reg),
		.prog_data(prog_data),
		.instr_reg(instr_reg),
		.instr_valid_reg(instr_valid_reg),
		.call_req(call_req),
		.call_target(call_target),
		.jump_req(jump_req),
		.jump_target(jump_target),
		.irq_pending(irq_pending),
		.irq_ack_reg(irq_ack_reg),
		.io_we(io_we),
		.io_addr(io_addr),
		.io_wdata(io_wdata),
		.io_rdata_reg(io_rdata_reg),
		.data_addr_reg(data_addr_reg),
		.data_wdata_reg(data_wdata_reg),
		.data_we_reg(data_we_reg)
	);
	mem_model mdl (
		.clk_sys(clk_sys),
		.data_we_reg(data_we_reg),
		.prog_addr_reg(prog_addr_reg),
		.data_addr_reg(data_addr_reg),
		.data_wdata_reg(data_wdata_reg),
		.prog_data(prog_data)
	);
	initial forever #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc > 500) begin
			error_cnt++;
			end_sim;
		end
	end
	task end_sim; begin
		$display("%0d checks %0d errors", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	end endtask
	task tk(input integer n); begin repeat (n) @(posedge clk_sys); #1; end endtask
	task io(input [5:0] a, input [7:0] d, input w); begin
		io_addr = a; io_wdata = d; io_we = w; tk(1); io_we = 0; tk(1);
	end endtask
	task t_run; begin
		for (i = 0; i < 4; i++) begin
			r = prog_addr_reg - 16'h0001;
			`CHK("ins", {r[7:0], ~r[7:0]}, instr_reg)
			tk(1);
			`CHK("pc", r + 16'h0002, prog_addr_reg)
		end
		$display("run end");
	end endtask
	task t_call; begin
		io(6'h3E, 8'h01, 1); io(6'h3D, 8'h20, 1); io(6'h3D, 8'h00, 0);
		`CHK("spl", 8'h20, io_rdata_reg)
		io(6'h3E, 8'h00, 0);
		`CHK("sph", 8'h01, io_rdata_reg)
		r = prog_addr_reg - 16'h0001; call_target = 16'h0040; call_req = 1; tk(1); call_req = 0; tk(4);
		`CHK("lo", r[7:0], mdl.sram[9'h120])
		`CHK("hi", r[15:8], mdl.sram[9'h11F])
		`CHK("tgt", 16'h40BF, instr_reg)
		io(6'h3D, 8'h00, 0);
		`CHK("sp2", 8'h1E, io_rdata_reg)
		$display("call end");
	end endtask
	task t_jump; begin
		jump_target = 16'h0123;
		jump_req = 1;
		tk(1);
		jump_req = 0;
		`CHK("jaddr", 16'h0123, prog_addr_reg)
		`CHK("jbubble", 1'b0, instr_valid_reg)
		tk(2);
		`CHK("jinstr", 16'h23DC, instr_reg)
		`CHK("jvalid", 1'b1, instr_valid_reg)
		$display("jump end");
	end endtask
	task t_irq; begin
		io(6'h3F, 8'h00, 1); irq_pending = 8'h0C; tk(4);
		`CHK("mask", 1'b1, instr_valid_reg)
		io(6'h3F, 8'h80, 1); tk(2);
		`CHK("ack", 8'h04, irq_ack_reg)
		`CHK("vec", 16'h0004, prog_addr_reg)
		irq_pending = 0; io(6'h3F, 8'h00, 0);
		`CHK("gie", 8'h00, io_rdata_reg)
		$display("irq end");
	end endtask
	initial begin
		tk(4); rst_n = 1; tk(2);
		t_run;
		t_jump;
		t_call;
		t_irq;
		end_sim;
	end
endmodule
